// ==== pkg/fipc_regs.svh ====
`ifndef FIPC_REGS_SVH
`define FIPC_REGS_SVH

// Widths and counts
`define FIPC_NUM_INPUTS      8
`define FIPC_ADC_BITS        10
`define FIPC_NUM_AXES        3
`define FIPC_SYNC_STAGES     3
// Synchroniser bus: user inputs on top, then fast, reset, pulse, direction, clear
`define FIPC_RAW_BITS        13
`define FIPC_BIT_FAST        4
`define FIPC_BIT_PULSE       2
`define FIPC_BIT_CRST        0
// Read value of floating inputs
`define FIPC_USER_IDLE       8'hff
// Capture deadline, in nanoseconds, and the core clock period
`define FIPC_CAPTURE_MAX_NS  30000
`define FIPC_CLK_PERIOD_NS   4
// Cycles held in system reset after the line drops
`define FIPC_RESET_STRETCH   16

`endif

// ==== pkg/fipc_pkg.sv ====
package fipc_pkg;

   typedef struct packed {
      logic pulse;
      logic direction;
      logic counter_reset;
   } fipc_pulse_pins_t;

   typedef struct packed {
      logic [9:0] analog_channel_one_value;
      logic [9:0] analog_channel_two_value;
      logic [9:0] analog_channel_three_value;
   } fipc_analog_t;

endpackage

// ==== rtl/fipc_field_io.sv ====
`timescale 1ns/10ps
`include "fipc_regs.svh"
// Functional notes
// - Input reads 1 floating/low, 0 driven
// - Eight inputs, each may raise interrupt
// - Three analog channels readable, 10 bit
// - Capture positions within 30 microseconds
// - Edge capture latches all axes together
// - System reset line forces full reset
// - Counter steps on both pulse edges
// - Rising counter reset edge clears counter
// - Direction low counts up, high down
// - Counter readable anytime, no disturbance
module fipc_field_io #(
   parameter int CNT_W = 32,                          // Pulse counter width
   parameter int POS_W = 32                           // Axis position width
) (
   input  wire logic                  core_clk,       // Core clock, 250 MHz
   input  wire logic                  nrst,           // Async reset, active low
   input  wire logic [7:0]            user_in_pin,    // Opto levels, 1 = field supply
   input  wire logic [7:0]            irq_enable,     // Per-input interrupt enable
   input  wire logic                  fast_capture_pin, // Fast capture line
   input  wire logic                  sys_reset_pin,  // External system reset line
   input  wire fipc_pkg::fipc_pulse_pins_t pulse_pins, // Pulse, direction, reset
   input  wire fipc_pkg::fipc_analog_t adc_in,        // Converter results
   input  wire logic [3*POS_W-1:0]    axis_pos,       // Live positions, axis 0 low
   output logic [7:0]                 user_inputs,    // Inputs as read
   output logic [7:0]                 input_interrupt_handler, // Edge pulse per input
   output fipc_pkg::fipc_analog_t     analog_values,  // Registered readings
   output logic [3*POS_W-1:0]         captured_axis_positions, // Latched positions
   output logic                       capture_done,   // One-cycle capture strobe
   output logic                       system_reset_req, // Full reset request
   output logic [CNT_W-1:0]           pulse_count     // Pulse counter value
);

   localparam int RAW_W = `FIPC_RAW_BITS;

   // ==========================================================
   // Input synchronisers
   // ==========================================================
   logic [RAW_W-1:0] raw;
   logic [RAW_W-1:0] sync1;
   logic [RAW_W-1:0] sync2;
   logic [RAW_W-1:0] sync3;
   logic [RAW_W-1:0] stable;
   logic [RAW_W-1:0] next_stable;

   // Order must match the bit positions named in the header
   assign raw = {user_in_pin, fast_capture_pin, sys_reset_pin,
                 pulse_pins.pulse, pulse_pins.direction, pulse_pins.counter_reset};

   // A level is accepted only when stages two and three agree
   always_comb begin
      for (int i = 0; i < RAW_W; i++) begin
         next_stable[i] = (sync2[i] == sync3[i]) ? sync3[i] : stable[i];
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         sync1  <= '0;
         sync2  <= '0;
         sync3  <= '0;
         stable <= '0;
      end else begin
         sync1  <= raw;
         sync2  <= sync1;
         sync3  <= sync2;
         stable <= next_stable;
      end
   end

   logic [RAW_W-1:0] prev;
   logic [7:0]       s_user;
   logic             s_fast;
   logic             s_sysrst;
   logic             s_pulse;
   logic             s_dir;
   logic             s_crst;

   assign {s_user, s_fast, s_sysrst, s_pulse, s_dir, s_crst} = stable;

   // Previous copy of accepted levels, for edge detection
   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         prev <= '0;
      end else begin
         prev <= stable;
      end
   end

   function automatic logic rise(input logic now, input logic was);
      return now & ~was;
   endfunction

   // ==========================================================
   // User inputs and interrupts
   // ==========================================================
   logic [7:0] next_user_inputs;
   logic [7:0] next_irq;
   logic [7:0] prev_user;

   assign prev_user = prev[RAW_W-1 -: `FIPC_NUM_INPUTS];

   always_comb begin
      next_user_inputs = ~s_user;
      // Interrupt on an input going active (pin driven to supply)
      for (int i = 0; i < `FIPC_NUM_INPUTS; i++) begin
         next_irq[i] = irq_enable[i] & rise(s_user[i], prev_user[i]);
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         user_inputs             <= `FIPC_USER_IDLE;
         input_interrupt_handler <= 8'h00;
      end else begin
         user_inputs             <= next_user_inputs;
         input_interrupt_handler <= next_irq;
      end
   end

   // ==========================================================
   // Analog readings
   // ==========================================================
   fipc_pkg::fipc_analog_t next_analog;

   always_comb begin
      next_analog = adc_in;
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         analog_values <= '0;
      end else begin
         analog_values <= next_analog;
      end
   end

   // ==========================================================
   // Fast position capture
   // ==========================================================
   logic [3*POS_W-1:0] next_captured;
   logic               next_capture_done;
   logic               cap_edge;

   // Latency is a handful of cycles, far inside the deadline
   assign cap_edge = rise(s_fast, prev[`FIPC_BIT_FAST]);

   always_comb begin
      next_captured     = captured_axis_positions;
      next_capture_done = 1'b0;
      if (cap_edge) begin
         next_captured     = axis_pos;
         next_capture_done = 1'b1;
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         captured_axis_positions <= '0;
         capture_done            <= 1'b0;
      end else begin
         captured_axis_positions <= next_captured;
         capture_done            <= next_capture_done;
      end
   end

   // ==========================================================
   // System reset request
   // ==========================================================
   logic [4:0] rst_stretch;
   logic [4:0] next_rst_stretch;
   logic       next_sys_req;

   // Stretched so a short assertion still yields a clean reset
   always_comb begin
      next_rst_stretch = rst_stretch;
      if (s_sysrst) begin
         next_rst_stretch = 5'(`FIPC_RESET_STRETCH);
      end else if (rst_stretch != 5'h00) begin
         next_rst_stretch = rst_stretch - 5'h01;
      end
      next_sys_req = s_sysrst || (rst_stretch != 5'h00);
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         rst_stretch      <= 5'h00;
         system_reset_req <= 1'b0;
      end else begin
         rst_stretch      <= next_rst_stretch;
         system_reset_req <= next_sys_req;
      end
   end

   // ==========================================================
   // Pulse following counter
   // ==========================================================
   logic [CNT_W-1:0] next_count;
   logic             pulse_edge;

   // Source must stay under 50kHz; far slower than the sampler
   assign pulse_edge = s_pulse ^ prev[`FIPC_BIT_PULSE];

   // Counter clear has priority over a coincident pulse edge
   always_comb begin
      next_count = pulse_count;
      if (rise(s_crst, prev[`FIPC_BIT_CRST])) begin
         next_count = '0;
      end else if (pulse_edge) begin
         if (s_dir) begin
            next_count = pulse_count - CNT_W'(1);
         end else begin
            next_count = pulse_count + CNT_W'(1);
         end
      end
   end

   always_ff @(posedge core_clk or negedge nrst) begin
      if (!nrst) begin
         pulse_count <= '0;
      end else begin
         pulse_count <= next_count;
      end
   end

endmodule // fipc_field_io

// ==== verif/fipc_field_io_chk.sv ====
`timescale 1ns/10ps
module fipc_field_io_chk #(
   parameter int CNT_W = 32, // Count
   parameter int POS_W = 32  // Pos
) (
   input wire logic                       core_clk,         // Clk
   input wire logic                       nrst,             // Rst
   input wire logic [7:0]                 user_in_pin,      // In
   input wire logic [7:0]                 irq_enable,       // En
   input wire logic                       fast_capture_pin, // Cap
   input wire logic                       sys_reset_pin,    // Sys
   input wire fipc_pkg::fipc_pulse_pins_t pulse_pins,       // Pulse
   input wire fipc_pkg::fipc_analog_t     adc_in,           // Adc
   input wire logic [3*POS_W-1:0]         axis_pos,         // Pos
   input wire logic [7:0]                 user_inputs,      // Read
   input wire logic [7:0]                 input_interrupt_handler, // Irq
   input wire fipc_pkg::fipc_analog_t     analog_values,    // Val
   input wire logic [3*POS_W-1:0]         captured_axis_positions, // Got
   input wire logic                       capture_done,     // Done
   input wire logic                       system_reset_req, // Req
   input wire logic [CNT_W-1:0]           pulse_count       // Cnt
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!nrst);
   // ==========
   // Properties
   property p_inv; $stable(user_in_pin)[*8] |-> user_inputs == ~user_in_pin; endproperty
   a_inv: assert property (p_inv) else $error("bad read");
   property p_irq; $rose(user_in_pin[0]) && irq_enable[0] |->
      ##[3:8] input_interrupt_handler[0]; endproperty
   a_irq: assert property (p_irq) else $error("no irq");
   property p_adc; $past(nrst) |-> analog_values == $past(adc_in); endproperty
   a_adc: assert property (p_adc) else $error("bad adc");
   property p_cap; $rose(fast_capture_pin) |-> ##[3:8] capture_done; endproperty
   a_cap: assert property (p_cap) else $error("late cap");
   property p_capv; capture_done |-> captured_axis_positions == $past(axis_pos); endproperty
   a_capv: assert property (p_capv) else $error("bad cap");
   property p_rst; sys_reset_pin[*8] |-> system_reset_req; endproperty
   a_rst: assert property (p_rst) else $error("no reset");
   property p_edge; $changed(pulse_pins.pulse) |-> ##[3:8] $changed(pulse_count); endproperty
   a_edge: assert property (p_edge) else $error("no step");
   property p_clr; $rose(pulse_pins.counter_reset) |-> ##[3:8] pulse_count == 0; endproperty
   a_clr: assert property (p_clr) else $error("no clear");
   property p_step; $changed(pulse_count) && pulse_count != 0 |->
      // Direction as it stood when the pulse edge entered the synchroniser
      pulse_count == $past(pulse_count) + CNT_W'($past(pulse_pins.direction, 5) ? -1 : 1);
   endproperty
   a_step: assert property (p_step) else $error("bad dir");
   property p_sync; $changed(pulse_pins.pulse) |=> $stable(pulse_count); endproperty
   a_sync: assert property (p_sync) else $error("too fast");
   c_cap: cover property (capture_done);
   c_rst: cover property (system_reset_req);
   c_irq: cover property (|input_interrupt_handler);
endmodule // fipc_field_io_chk
bind fipc_field_io fipc_field_io_chk #(.CNT_W(CNT_W), .POS_W(POS_W)) chk (.*);

// ==== verif/fipc_pulse_src.sv ====
`timescale 1ns/10ps
module fipc_pulse_src (
   input  wire logic                 core_clk, // Clk
   output fipc_pkg::fipc_pulse_pins_t pins     // Pins
);
   initial pins = '0;
   // 2500 cycles per edge keeps the train at 50kHz
   task automatic step(int n, logic dir);
      pins.direction = dir;
      repeat (n) begin
         repeat (2500) @(posedge core_clk);
         #1 pins.pulse = ~pins.pulse;
      end
   endtask
   // Clear lands on a pulse edge on purpose
   task automatic clear();
      repeat (2500) @(posedge core_clk);
      #1 pins = '{~pins.pulse, pins.direction, 1'b1};
      repeat (2500) @(posedge core_clk);
      #1 pins.counter_reset = 1'b0;
   endtask
endmodule // fipc_pulse_src

// ==== verif/test_field_io_pulse_counter.sv ====
`timescale 1ns/10ps
module test_field_io_pulse_counter;
   typedef struct {logic [7:0] pin, ui;} fipc_row_t;
   fipc_row_t rows[3] = '{'{8'ha5, 8'h5a}, '{8'hff, 8'h00}, '{8'h00, 8'hff}};
   logic                       core_clk, nrst, fast_capture_pin, sys_reset_pin;
   logic [7:0]                 user_in_pin, irq_enable, user_inputs, iih, seen;
   fipc_pkg::fipc_pulse_pins_t pulse_pins;
   fipc_pkg::fipc_analog_t     adc_in, analog_values;
   logic [95:0]                axis_pos, captured_axis_positions;
   logic                       capture_done, system_reset_req;
   logic [31:0]                pulse_count;
   int                         fails, total_checks, n;
   fipc_field_io dut (.core_clk(core_clk), .nrst(nrst), .user_in_pin(user_in_pin),
      .irq_enable(irq_enable), .fast_capture_pin(fast_capture_pin),
      .sys_reset_pin(sys_reset_pin), .pulse_pins(pulse_pins), .adc_in(adc_in),
      .axis_pos(axis_pos), .user_inputs(user_inputs), .input_interrupt_handler(iih),
      .analog_values(analog_values), .captured_axis_positions(captured_axis_positions),
      .capture_done(capture_done), .system_reset_req(system_reset_req),
      .pulse_count(pulse_count));
   fipc_pulse_src src (.core_clk(core_clk), .pins(pulse_pins));
   task automatic tick(int k);
      repeat (k) @(posedge core_clk);
      #1;
   endtask
   task automatic cmp(logic [95:0] got, exp);
      total_checks++;
      if (got !== exp) begin
         fails++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic end_sim();
      $display("checks %0d fails %0d", total_checks, fails);
      if (fails == 0 && total_checks > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   always @(posedge core_clk) begin
      if (!nrst) seen <= '0;
      else seen <= seen | iih;
   end
   initial begin
      core_clk = 0;
      forever #2 core_clk = ~core_clk;
   end
   // Whole run needs about 30200 cycles
   initial begin
      tick(50000);
      fails++;
      end_sim();
   end
   initial begin
      {nrst, fast_capture_pin, sys_reset_pin, user_in_pin} = '0;
      {adc_in, axis_pos} = '0;
      irq_enable = 8'h0f;
      tick(10);
      cmp(user_inputs, 8'hff);
      nrst = 1;
      foreach (rows[i]) begin
         user_in_pin = rows[i].pin;
         adc_in = {3{rows[i].pin, rows[i].pin[1:0]}};
         tick(10);
         cmp(user_inputs, rows[i].ui);
         cmp(analog_values, {3{rows[i].pin, rows[i].pin[1:0]}});
      end
      cmp(seen, 8'h0f);
      sys_reset_pin = 1;
      tick(20);
      cmp(system_reset_req, 1'b1);
      sys_reset_pin = 0;
      tick(40);
      cmp(system_reset_req, 1'b0);
      src.step(4, 1'b0);
      tick(20);
      cmp(pulse_count, 32'h0000_0004);
      tick(5);
      cmp(pulse_count, 32'h0000_0004);
      src.step(6, 1'b1);
      tick(20);
      cmp(pulse_count, 32'hffff_fffe);
      src.clear();
      cmp(pulse_count, 32'h0000_0000);
      axis_pos = {32'h0000_0003, 32'h0000_0002, 32'h0000_0001};
      fast_capture_pin = 1;
      for (n = 0; n < 7500 && capture_done !== 1'b1; n++) tick(1);
      cmp(n < 7500, 1'b1);
      cmp(captured_axis_positions, axis_pos);
      axis_pos = ~axis_pos;
      fast_capture_pin = 0;
      tick(20);
      cmp(captured_axis_positions, ~axis_pos);
      end_sim();
   end
endmodule // test_field_io_pulse_counter
